// File: bench/bsc_ctl_model.sv
// Purpose: behavioural boundary-scan test controller driving the test pins
// Assumes: mclk is only a pacing reference; test clock period is 16 mclk
// Notes:   the test clock stands low between calls, as a real controller
`timescale 1ns/10ps
module bsc_ctl_model (
    input  wire logic mclk,
    output logic      test_clock,
    output logic      test_mode_select,
    output logic      test_serial_in,
    output logic      test_reset_n,
    input  wire logic test_serial_out,
    input  wire logic test_serial_out_oe
);
    // pins idle: clock low, reset released
    initial begin
        test_clock       = 1'b0;
        test_mode_select = 1'b1;
        test_serial_in   = 1'b0;
        test_reset_n     = 1'b1;
    end

    // one test clock period; serial out is read just before the rise,
    // so it returns what the previous falling edge presented
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
        @(negedge mclk);
        test_mode_select = tms;
        test_serial_in   = tdi;
        repeat (7) @(negedge mclk);
        // a released output floats: read it as the inverse, never a stale copy
        tdo        = test_serial_out_oe ? test_serial_out : ~test_serial_out;
        oe         = test_serial_out_oe;
        test_clock = 1'b1;
        repeat (8) @(negedge mclk);
        test_clock     = 1'b0;
        // data is no longer valid: show the inverse, not a stale copy
        test_serial_in = ~tdi;
    endtask

    // pulse the test reset pin well beyond the synchroniser depth
    task automatic reset_pulse;
        @(negedge mclk);
        test_reset_n = 1'b0;
        repeat (6) @(negedge mclk);
        test_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
endmodule

// File: bench/bsc_scan_top_test.sv
// Purpose: self-checking bench for the instruction and test data registers
// Assumes: the controller model steps the tap; all pins change at falling mclk
// Notes:   every data scan is a full 73-bit pass so one expectation form fits all
`timescale 1ns/10ps
module bsc_scan_top_test;
    import bsc_pkg::*;
    localparam logic [ID_VER_W-1:0] VER = 4'h9;      // arbitrary value
    localparam logic [ID_DEV_W-1:0] DEV = 16'h3C5A;  // arbitrary value
    localparam logic [ID_MFR_W-1:0] MKR = 11'h2B6;   // arbitrary value
    localparam logic [ID_W-1:0]     ID_EXP = {VER, DEV, MKR, ID_MARK};
    localparam logic [BSR_W-1:0]    PAT_A  = 73'h1_2345_6789_ABCD_EF01_23;
    localparam logic [BSR_W-1:0]    PAT_B  = 73'h0_F0E1_D2C3_B4A5_9687_78;
    localparam logic [BSR_W-1:0]    PAT_C  = 73'h1_5A5A_C3C3_3C3C_A5A5_0F;
    localparam int                  LIMIT  = 30000;  // mclk cycles, about 2.4 times the run

    logic                 mclk = 1'b0;  // system clock
    logic                 nrst;         // async reset, active low
    logic                 test_clock;   // driven by the controller model
    logic                 test_mode_select;
    logic                 test_serial_in;
    logic                 test_reset_n;
    logic                 test_serial_out;
    logic                 test_serial_out_oe;
    logic [BSR_W-1:0]     pin_sample;   // pin levels seen by boundary cells
    logic [BSR_W-1:0]     cell_out;
    logic                 cells_drive;
    logic                 pins_high_z;
    logic [IR_W-1:0]      instruction;
    int                   bad_count;
    int                   checked;
    int                   cycles;

    bsc_scan_top #(.ID_VERSION(VER), .ID_DEVICE(DEV), .ID_MAKER(MKR)) i_dut (
        .mclk(mclk), .nrst(nrst), .test_clock(test_clock),
        .test_mode_select(test_mode_select), .test_serial_in(test_serial_in),
        .test_reset_n(test_reset_n), .test_serial_out(test_serial_out),
        .test_serial_out_oe(test_serial_out_oe), .pin_sample(pin_sample),
        .cell_out(cell_out), .cells_drive(cells_drive), .pins_high_z(pins_high_z),
        .instruction(instruction));

    bsc_ctl_model i_ctl (
        .mclk(mclk), .test_clock(test_clock), .test_mode_select(test_mode_select),
        .test_serial_in(test_serial_in), .test_reset_n(test_reset_n),
        .test_serial_out(test_serial_out), .test_serial_out_oe(test_serial_out_oe));

    // 100 MHz system clock
    always #5 mclk = ~mclk;

    // hang guard: a run past the ceiling is a failure
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            conclude();
        end
    end

    task automatic cmp_vec(input logic [BSR_W-1:0] got, input logic [BSR_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_vec({{(BSR_W-1){1'b0}}, got}, {{(BSR_W-1){1'b0}}, exp});
    endtask

    // shift a new instruction from idle and return to idle
    task automatic load_ir(input logic [IR_W-1:0] code);
        logic [IR_W-1:0] seen;
        logic [IR_W-1:0] old;
        logic            t;
        logic            o;
        old = instruction;
        i_ctl.step(1'b1, 1'b0, t, o);
        i_ctl.step(1'b1, 1'b0, t, o);
        i_ctl.step(1'b0, 1'b0, t, o);
        i_ctl.step(1'b0, 1'b0, t, o);
        for (int i = 0; i < IR_W; i++) begin
            i_ctl.step(i == IR_W - 1, code[i], seen[i], o);
        end
        cmp_vec(BSR_W'(instruction), BSR_W'(old));
        i_ctl.step(1'b1, 1'b0, t, o);
        repeat (6) @(negedge mclk);
        cmp_vec(BSR_W'(instruction), BSR_W'(code));
        i_ctl.step(1'b0, 1'b0, t, o);
        cmp_vec(BSR_W'(seen), BSR_W'(IR_CAPTURE));
    endtask

    // full data scan from idle back to idle; latches must hold while shifting
    task automatic dr_scan(input logic [BSR_W-1:0] din, input logic [BSR_W-1:0] exp);
        logic [BSR_W-1:0] dout;
        logic [BSR_W-1:0] keep;
        logic             o;
        logic             oe_mid;
        logic             t;
        keep = cell_out;
        i_ctl.step(1'b1, 1'b0, t, o);
        i_ctl.step(1'b0, 1'b0, t, o);
        i_ctl.step(1'b0, 1'b0, t, o);
        for (int i = 0; i < BSR_W; i++) begin
            i_ctl.step(i == BSR_W - 1, din[i], dout[i], o);
            if (i == 1) begin
                oe_mid = o;
            end
        end
        cmp_vec(cell_out, keep);
        i_ctl.step(1'b1, 1'b0, t, o);
        cmp_bit(oe_mid, 1'b1);
        cmp_bit(o, 1'b0);
        i_ctl.step(1'b0, 1'b0, t, o);
        cmp_vec(dout, exp);
    endtask

    // identification read straight after a reset of either kind
    task automatic t_reset_id;
        logic t;
        logic o;
        cmp_vec(BSR_W'(instruction), BSR_W'(INS_IDCODE));
        cmp_bit(test_serial_out_oe, 1'b0);
        i_ctl.step(1'b0, 1'b0, t, o);
        dr_scan(PAT_A, {PAT_A[BSR_W-ID_W-1:0], ID_EXP});
    endtask

    // sample pins, preload the boundary latches
    task automatic t_sample;
        @(negedge mclk);
        pin_sample = PAT_C;
        load_ir(INS_SAMPLE);
        cmp_bit(cells_drive, 1'b0);
        dr_scan(PAT_B, PAT_C);
        cmp_vec(cell_out, PAT_B);
    endtask

    // outputs come from latches; capture samples inputs
    task automatic t_extest;
        @(negedge mclk);
        pin_sample = PAT_A;
        load_ir(INS_EXTEST);
        cmp_bit(cells_drive, 1'b1);
        cmp_vec(cell_out, PAT_B);
        dr_scan(PAT_C, PAT_A);
        cmp_vec(cell_out, PAT_C);
    endtask

    // every code that selects the one-bit path, two unknown ones too
    task automatic t_bypass;
        logic [IR_W-1:0] codes [5];
        codes = '{INS_BYPASS, INS_CLAMP, INS_HIGHZ, 3'h5, 3'h6};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            cmp_bit(cells_drive, codes[k] == INS_CLAMP);
            cmp_bit(pins_high_z, codes[k] == INS_HIGHZ);
            dr_scan(PAT_B, {PAT_B[BSR_W-2:0], BYPASS_CAP});
            cmp_vec(cell_out, PAT_C);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence; the reset pin return ends in an identification read
    initial begin
        nrst       = 1'b0;
        pin_sample = '0;
        bad_count  = 0;
        checked    = 0;
        cycles     = 0;
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        t_reset_id();
        t_sample();
        t_extest();
        t_bypass();
        i_ctl.reset_pulse();
        cmp_bit(pins_high_z, 1'b0);
        t_reset_id();
        conclude();
    end
endmodule

// File: core/bsc_pkg.sv
// Purpose: shared constants and types for the boundary-scan test logic
// Assumes: one system clock samples the slow test clock pins
// Notes:   instruction codes, register widths and capture values live here
package bsc_pkg;
    // controller states, tracked in the sampling domain
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bsc_state_t;

    localparam int IR_W   = 3;           // instruction register length
    localparam int ID_W   = 32;          // identification register length
    localparam int BSR_W  = 73;          // boundary cells, bit 0 up to bit 72
    localparam int SYNC_N = 2;           // synchroniser depth for pins

    // instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h2;
    localparam logic [IR_W-1:0] INS_CLAMP  = 3'h3;
    localparam logic [IR_W-1:0] INS_HIGHZ  = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    // fixed pattern loaded in capture-ir, two low bits 01 as usual
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // identification field layout
    localparam int ID_MFR_W = 11;
    localparam int ID_DEV_W = 16;
    localparam int ID_VER_W = 4;
    localparam logic       ID_MARK     = 1'h1;  // fixed one in the lsb
    localparam logic       BYPASS_CAP  = 1'h0;  // bypass cell captures zero
    localparam logic       PIN_RESET   = 1'h0;  // reset value of sampled bits
endpackage

// File: core/bsc_scan_top.sv
// Purpose: instruction register, decode and test data registers
// Assumes: test pins are asynchronous to mclk and sampled twice before use
// Notes:   rising test clock captures and shifts, falling one updates and drives out
`timescale 1ns/10ps
// Notes on behaviour
// - three-bit instruction shift stage plus latch
// - shift-ir moves instruction bits toward output
// - instruction latched on falling edge while in update-ir
// - sample/preload captures pins, shifts boundary cells
// - bypass code routes through one-bit register
// - extest drives outputs from boundary latches
// - clamp holds outputs, selects bypass path
// - highz floats outputs, selects bypass path
// - idcode captures identification value, shifts it
// - test-logic-reset forces identification instruction
// - id layout: one, maker, device, version
// - identification has shift stage and latch
// - bypass is single-bit shift stage
// - boundary register spans bits 0 to 72
// - controller steps on rising test clock
// - update-dr latches shift stage on falling edge
module bsc_scan_top
    import bsc_pkg::*;
#(
    parameter logic [ID_VER_W-1:0] ID_VERSION = 4'h0,     // arbitrary value
    parameter logic [ID_DEV_W-1:0] ID_DEVICE  = 16'h00A5, // arbitrary value
    parameter logic [ID_MFR_W-1:0] ID_MAKER   = 11'h055   // arbitrary value
)(
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire logic                    test_clock,
    input  wire logic                    test_mode_select,
    input  wire logic                    test_serial_in,
    input  wire logic                    test_reset_n,
    output logic                         test_serial_out,
    output logic                         test_serial_out_oe,
    input  wire logic [bsc_pkg::BSR_W-1:0] pin_sample,
    output logic [bsc_pkg::BSR_W-1:0]   cell_out,
    output logic                         cells_drive,
    output logic                         pins_high_z,
    output logic [bsc_pkg::IR_W-1:0]    instruction
);
    import bsc_pkg::*;

    bsc_tap_if tap ();                     // state and edges from the tracker

    bsc_tap_track u_track (
        .mclk             (mclk),
        .nrst             (nrst),
        .test_clock       (test_clock),
        .test_mode_select (test_mode_select),
        .test_serial_in   (test_serial_in),
        .test_reset_n     (test_reset_n),
        .tap              (tap)
    );

    // identification value: mark in bit 0, then maker, device and version upward
    // maker, part and version are parameters so that no fixed code is built in
    localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_DEVICE, ID_MAKER, ID_MARK};

    logic [BSR_W-1:0] pin_s1;             // first stage, read only by pin_s2
    logic [BSR_W-1:0] pin_s2;             // synchronised pin levels
    logic [IR_W-1:0]  ir_shift;           // instruction shift stage
    logic [IR_W-1:0]  ir;                 // current instruction
    logic             bypass;             // one-bit bypass cell
    logic [ID_W-1:0]  id_shift;           // identification shift stage
    logic [ID_W-1:0]  id_par;             // identification latch
    logic [BSR_W-1:0] bsr_shift;          // boundary shift stage
    logic [BSR_W-1:0] bsr_par;            // boundary latch

    // decode of the current instruction; unknown codes take the bypass path
    wire sel_bsr = (ir == INS_SAMPLE) || (ir == INS_EXTEST);
    wire sel_id  = (ir == INS_IDCODE);
    wire sel_byp = !sel_bsr && !sel_id;
    wire in_reset = (tap.state == ST_RESET);
    wire shifting = (tap.state == ST_SHIFT_IR) || (tap.state == ST_SHIFT_DR);
    wire dr_lsb   = sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass);
    wire next_tdo = (tap.state == ST_SHIFT_IR) ? ir_shift[0] : dr_lsb;
    wire cap_dr   = tap.rise && tap.state == ST_CAP_DR;
    wire sh_dr    = tap.rise && tap.state == ST_SHIFT_DR;
    wire upd_dr   = tap.fall && tap.state == ST_UPD_DR;

    // pin sample synchroniser; pins are free-running device signals
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pin_sample;
            pin_s2 <= pin_s1;
        end
    end

    // instruction shift stage: fixed load in capture, lsb first out
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ir_shift <= IR_CAPTURE;
        end else if (tap.rise && tap.state == ST_CAP_IR) begin
            ir_shift <= IR_CAPTURE;
        end else if (tap.rise && tap.state == ST_SHIFT_IR) begin
            ir_shift <= {tap.tdi, ir_shift[IR_W-1:1]};
        end
    end

    // current instruction: forced in reset, else latched on update fall
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ir <= INS_IDCODE;
        end else if (in_reset) begin
            ir <= INS_IDCODE;
        end else if (tap.fall && tap.state == ST_UPD_IR) begin
            ir <= ir_shift;
        end
    end

    // bypass cell: captures zero, shifts one bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bypass <= BYPASS_CAP;
        end else if (cap_dr && sel_byp) begin
            bypass <= BYPASS_CAP;
        end else if (sh_dr && sel_byp) begin
            bypass <= tap.tdi;
        end
    end

    // identification stage and latch; reset loads the value into the latch too
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            id_shift <= ID_VALUE;
            id_par   <= ID_VALUE;
        end else begin
            if (cap_dr && sel_id) begin
                id_shift <= ID_VALUE;
            end else if (sh_dr && sel_id) begin
                id_shift <= {tap.tdi, id_shift[ID_W-1:1]};
            end
            if (upd_dr && sel_id) begin
                id_par <= id_shift;
            end
        end
    end

    // boundary cells: capture pins, shift, latch on update fall only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bsr_shift <= '0;
            bsr_par   <= '0;
        end else begin
            if (cap_dr && sel_bsr) begin
                bsr_shift <= pin_s2;
            end else if (sh_dr && sel_bsr) begin
                bsr_shift <= {tap.tdi, bsr_shift[BSR_W-1:1]};
            end
            if (upd_dr && sel_bsr) begin
                bsr_par <= bsr_shift;
            end
        end
    end

    // serial output changes on the falling test clock, floats outside the shift states
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            test_serial_out    <= 1'h0;
            test_serial_out_oe <= 1'h0;
        end else if (tap.fall) begin
            test_serial_out    <= shifting ? next_tdo : 1'h0;
            test_serial_out_oe <= shifting;
        end
    end

    // output control follows the latched instruction; clamp never reloads bsr_par
    assign cells_drive = (ir == INS_EXTEST) || (ir == INS_CLAMP);
    assign pins_high_z = (ir == INS_HIGHZ);
    assign cell_out    = bsr_par;
    assign instruction = ir;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // checks run on mclk; every test clock event is a one-cycle pulse here
    a_ir_latch: assert property (tap.fall && tap.state == ST_UPD_IR && !in_reset
        |=> ir == $past(ir_shift)) else $error("instruction not latched");
    a_ir_shift: assert property (tap.rise && tap.state == ST_SHIFT_IR
        |=> ir_shift == {$past(tap.tdi), $past(ir_shift[IR_W-1:1])})
        else $error("instruction shift wrong");
    a_ir_hold: assert property (!tap.fall && !in_reset |=> $stable(ir))
        else $error("instruction changed off update");
    a_reset_id: assert property (in_reset |=> ir == INS_IDCODE)
        else $error("reset did not force idcode");
    a_id_capture: assert property (cap_dr && sel_id |=> id_shift == ID_VALUE)
        else $error("id value not captured");
    // layout held against the package mark and the version parameter
    a_id_mark: assert property (cap_dr && sel_id |=> id_shift[0] == ID_MARK
        && id_shift[ID_W-1 -: ID_VER_W] == ID_VERSION) else $error("id layout wrong");
    a_id_latch: assert property (upd_dr && sel_id |=> id_par == $past(id_shift))
        else $error("id latch not updated");
    a_bsr_capture: assert property (cap_dr && sel_bsr
        |=> bsr_shift == $past(pin_s2)) else $error("pins not captured");
    a_bsr_shift: assert property (sh_dr && sel_bsr
        |=> bsr_shift == {$past(tap.tdi), $past(bsr_shift[BSR_W-1:1])})
        else $error("boundary shift wrong");
    a_bypass_path: assert property (sh_dr && sel_byp |=> bypass == $past(tap.tdi))
        else $error("bypass did not shift");
    a_upd_dr: assert property (upd_dr && sel_bsr |=> bsr_par == $past(bsr_shift))
        else $error("boundary latch not updated");
    a_clamp_hold: assert property (ir == INS_CLAMP ##1 ir == INS_CLAMP
        |-> $stable(bsr_par) && cells_drive) else $error("clamp outputs moved");
    a_highz_float: assert property (ir == INS_HIGHZ
        |-> pins_high_z && !cells_drive) else $error("highz not floating");
    a_extest_drive: assert property (ir == INS_EXTEST
        |-> cells_drive && sel_bsr) else $error("extest not driving");
    a_sample_quiet: assert property (ir == INS_SAMPLE
        |-> !cells_drive && !pins_high_z) else $error("sample disturbed the pins");
    a_tdo_float: assert property (tap.fall && !shifting |=> !test_serial_out_oe)
        else $error("serial output driven outside shift");
    a_tdo_drive: assert property (tap.fall && shifting
        |=> test_serial_out_oe && test_serial_out == $past(next_tdo))
        else $error("serial output not driven while shifting");

    // scenario covers; unknown codes share the bypass path and need none of their own
    c_id_read:  cover property (sel_id && sh_dr ##[1:400] test_serial_out_oe);
    c_ir_load:  cover property (tap.fall && tap.state == ST_UPD_IR);
    c_extest:   cover property (ir == INS_EXTEST && upd_dr);
    c_clamp:    cover property (ir == INS_CLAMP && sh_dr);
    c_sample:   cover property (ir == INS_SAMPLE && cap_dr);
endmodule

// File: core/bsc_tap_if.sv
// Purpose: carries controller state and test clock edges between modules
// Assumes: all signals are in the mclk domain
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/10ps
interface bsc_tap_if;
    import bsc_pkg::*;
    bsc_state_t state;   // current controller state
    logic       rise;    // test clock rising edge seen
    logic       fall;    // test clock falling edge seen
    logic       tms;     // mode select, synchronised
    logic       tdi;     // serial input, synchronised
    modport tracker (output state, rise, fall, tms, tdi);
    modport user    (input  state, rise, fall, tms, tdi);
endinterface

// File: core/bsc_tap_track.sv
// Purpose: samples the test pins and follows the test controller state
// Assumes: mclk is much faster than the test clock
// Notes:   pins pass two flops before any logic reads them
`timescale 1ns/10ps
module bsc_tap_track
    import bsc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic test_clock,
    input  wire logic test_mode_select,
    input  wire logic test_serial_in,
    input  wire logic test_reset_n,
    bsc_tap_if.tracker tap
);
    logic [3:0] sync1;         // first stage, read only by sync2
    logic [3:0] sync2;         // second stage: clk, tms, tdi, trst_n
    logic       clk_prev;      // delayed clock for edge finding
    bsc_state_t state;         // controller state
    bsc_state_t next_state;    // state after a rising edge
    wire        clk_s  = sync2[0];
    wire        tms_s  = sync2[1];
    wire        trst_s = sync2[3];
    wire        rise   = clk_s & ~clk_prev;
    wire        fall   = ~clk_s & clk_prev;

    // pin synchronisers and edge history
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1    <= 4'h8;
            sync2    <= 4'h8;
            clk_prev <= 1'h0;
        end else begin
            sync1    <= {test_reset_n, test_serial_in, test_mode_select, test_clock};
            sync2    <= sync1;
            clk_prev <= clk_s;
        end
    end

    // standard sixteen-state walk on mode select
    always_comb begin
        case (state)
            ST_RESET:    next_state = tms_s ? ST_RESET    : ST_IDLE;
            ST_IDLE:     next_state = tms_s ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = tms_s ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms_s ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms_s ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = tms_s ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = tms_s ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms_s ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms_s ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = tms_s ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    end

    // advance only on a rising test clock; the reset pin wins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_RESET;
        end else if (!trst_s) begin
            state <= ST_RESET;
        end else if (rise) begin
            state <= next_state;
        end
    end

    assign tap.state = state;
    assign tap.rise  = rise;
    assign tap.fall  = fall;
    assign tap.tms   = tms_s;
    assign tap.tdi   = sync2[2];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_state_advance: assert property (rise && trst_s && state == ST_RESET && !tms_s
        |=> state == ST_IDLE) else $error("idle not reached from reset");
    a_state_still: assert property (!rise && trst_s |=> $stable(state))
        else $error("state moved without a rising test clock");
endmodule
